// ==== pfc_bus_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// One strobed bus cycle on the flash pins
// ----------------------------------------
module pfc_bus_cycle (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Request
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  wdata,
	// Answer
	output logic             done,
	output logic [7:0]       rdata,
	// Flash pins
	output logic [18:0]      byte_address,
	output logic             chip_sel_n,
	output logic             out_en_n,
	output logic             wr_en_n,
	output logic [7:0]       data_lines_o,
	output logic             data_lines_oe_n,
	input  wire logic [7:0]  data_lines_i
);
	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_GAP} pfc_cyc_t;
	pfc_cyc_t   st_q;
	logic [7:0] cnt_q;
	logic       wr_q;
	wire        cnt_zero = (cnt_q == 8'h00);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q            <= S_IDLE;
			cnt_q           <= 8'h00;
			wr_q            <= 1'b0;
			done            <= 1'b0;
			rdata           <= 8'h00;
			byte_address    <= 19'h0_0000;
			chip_sel_n      <= 1'b1;
			out_en_n        <= 1'b1;
			wr_en_n         <= 1'b1;
			data_lines_o    <= 8'h00;
			data_lines_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			if (!cnt_zero)
				cnt_q <= cnt_q - 8'h01;
			unique case (st_q)
				S_IDLE: if (start) begin
					// Address settles before any strobe falls
					byte_address    <= addr;
					wr_q            <= is_write;
					data_lines_o    <= wdata;
					data_lines_oe_n <= !is_write;
					st_q            <= S_SETUP;
				end
				S_SETUP: begin
					chip_sel_n <= 1'b0;
					// R20 - OE high on writes
					out_en_n   <= wr_q;
					// R21 - Strobe outlasts filter
					wr_en_n    <= !wr_q;
					cnt_q      <= wr_q ? pfc_pkg::PW_CYC : pfc_pkg::RD_CYC;
					st_q       <= S_STROBE;
				end
				S_STROBE: if (cnt_zero) begin
					// R9 - Data held past rising edge
					chip_sel_n <= 1'b1;
					out_en_n   <= 1'b1;
					wr_en_n    <= 1'b1;
					rdata      <= data_lines_i;
					cnt_q      <= pfc_pkg::GP_CYC;
					st_q       <= S_GAP;
				end
				S_GAP: if (cnt_zero) begin
					data_lines_oe_n <= 1'b1;
					done            <= 1'b1;
					st_q            <= S_IDLE;
				end
			endcase
		end
	end
endmodule : pfc_bus_cycle
`default_nettype wire

// ==== pfc_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Behavioural flash device on the far side
// ----------------------------------------
module pfc_flash_model #(
	parameter int         PROG_NS  = 500,
	parameter int         ERASE_NS = 2000,
	// Identification values are arbitrary
	parameter logic [7:0] MFR_CODE = 8'h3C,
	parameter logic [7:0] DEV_CODE = 8'hC3
) (
	// Flash pins
	input  wire logic [18:0] byte_address,
	input  wire logic        chip_sel_n,
	input  wire logic        out_en_n,
	input  wire logic        wr_en_n,
	input  wire logic [7:0]  data_lines,
	// Device data output
	output logic      [7:0]  dq_out,
	output logic             dq_drive
);
	logic [7:0]  mem [int];
	logic [18:0] a_lat;
	logic [7:0]  last_d;
	logic        locked;
	logic        id_mode;
	logic        tog;
	int          step;
	realtime     t_fall;
	realtime     busy_until;
	wire logic   wstb = !chip_sel_n && !wr_en_n;
	wire logic   rstb = !chip_sel_n && !out_en_n && wr_en_n;

	initial begin
		dq_out = 8'h00;
		last_d = 8'hFF;
		locked = 1'b0;
		id_mode = 1'b0;
		tog = 1'b0;
		step = 0;
		busy_until = 0.0;
	end

	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
	endfunction : rd

	task automatic cmd(input logic [18:0] a, input logic [7:0] d);
		logic u;
		u = (a == 19'h0_5555);
		if (step == 0 && d == 8'hF0) id_mode = 1'b0;
		if (step == 2 && u && d == 8'h90) id_mode = 1'b1;
		if (step == 2 && u && d == 8'hF0) id_mode = 1'b0;
		if (step == 3 && !(locked && a <= 19'h0_3FFF)) begin
			mem[int'(a)] = rd(a) & d;
			last_d = d;
			busy_until = $realtime + PROG_NS;
		end
		if (step == 6 && u && d == 8'h40) locked = 1'b1;
		if (step == 6 && u && d == 8'h10) begin
			foreach (mem[k]) if (!(locked && k <= 16383)) mem[k] = 8'hFF;
			last_d = 8'hFF;
			busy_until = $realtime + ERASE_NS;
		end
		case (step)
			0: step = (u && d == 8'hAA) ? 1 : 0;
			1: step = (a == 19'h0_2AAA && d == 8'h55) ? 2 : 0;
			2: step = (u && d == 8'hA0) ? 3 : ((u && d == 8'h80) ? 4 : 0);
			4: step = (u && d == 8'hAA) ? 5 : 0;
			5: step = (a == 19'h0_2AAA && d == 8'h55) ? 6 : 0;
			default: step = 0;
		endcase
	endtask : cmd

	// drive only while selected for a read
	assign dq_drive = rstb;
	always @(posedge rstb) begin
		if (id_mode && byte_address <= 19'h0_0002) begin
			dq_out = (byte_address == 19'h0_0000) ? MFR_CODE :
				((byte_address == 19'h0_0001) ? DEV_CODE : {7'h00, locked});
		end else if ($realtime < busy_until) begin
			tog = !tog;
			dq_out = {~last_d[7], tog, last_d[5:0]};
		end else begin
			dq_out = rd(byte_address);
		end
	end
	// a released bus must not look like valid data
	always @(negedge rstb) dq_out = ~dq_out;
	// address taken at the later falling edge
	always @(posedge wstb) begin
		t_fall = $realtime;
		a_lat = byte_address;
	end
	// data at the earlier rising edge; short or inhibited strobes dropped
	always @(negedge wstb) begin
		if ($realtime - t_fall >= 15.0 && out_en_n === 1'b1 && $realtime >= busy_until) cmd(a_lat, data_lines);
	end
endmodule : pfc_flash_model
`default_nettype wire

// ==== pfc_host.sv ====
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Reads strobe chip select and output enable low, write enable high.
// R2 - Data pins only driven by device when both selects low.
// R3 - Erased bits read one; programming clears bits only.
// R4 - Chip erase sent as six fixed address/data writes.
// R5 - Erase timed internally; host polls until done.
// R6 - Locked boot sector survives chip erase.
// R7 - Programming a zero back to one has no effect.
// R8 - Byte program is a four-write sequence.
// R9 - Address latched late falling edge, data early rising edge.
// R10 - Byte program completes within program time, then next access.
// R11 - Boot block spans addresses zero to 3FFF.
// R12 - Locked boot block refuses erase and program.
// R13 - Host enables lockout with six command writes.
// R14 - In ID mode, address 2 bit 0 shows lockout.
// R15 - ID codes identical by hardware or software entry.
// R16 - Polling during program returns inverted bit 7.
// R17 - After program, true byte returned on all lines.
// R18 - Polling may begin at any moment.
// R19 - Bit 6 toggles between reads while busy.
// R20 - No program cycle with OE low, CE high or WE high.
// R21 - Strobe pulses under 15 ns ignored.
// R22 - Unlock 5555/AA, 2AAA/55, 5555/cmd; A0 program, 80..10 erase.
// R23 - Lockout sequence ends 5555/40.
// R24 - ID entry ends 90; exit ends F0 or single F0.
// R25 - Broken sequence returns device to read state.
// R26 - Program to locked boot address ignored.
module pfc_host (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Flash pins
	output logic [18:0]      byte_address,
	output logic             chip_sel_n,
	output logic             out_en_n,
	output logic             wr_en_n,
	output logic [7:0]       data_lines_o,
	output logic             data_lines_oe_n,
	input  wire logic [7:0]  data_lines_i
);
	typedef enum logic [2:0] {H_IDLE, H_CMD, H_POLL, H_READ, H_END} pfc_st_t;

	// ----------------------------------------
	// Command step table
	// ----------------------------------------
	function automatic logic [26:0] step(input logic [2:0] op, input logic [2:0] idx,
		input logic [18:0] a, input logic [7:0] d);
		logic [7:0] c;
		c = 8'h00;
		step = 27'h000_0000;
		unique case (op)
			pfc_pkg::OP_PROGRAM: c = pfc_pkg::CMD_PROG;
			pfc_pkg::OP_ID_IN:   c = pfc_pkg::CMD_ID_IN;
			pfc_pkg::OP_ID_OUT:  c = pfc_pkg::CMD_ID_OUT;
			default:             c = pfc_pkg::CMD_SETUP;
		endcase
		// R24 - Single exit write
		if (op == pfc_pkg::OP_ID_OUT1)
			step = {a, pfc_pkg::CMD_ID_OUT};
		// R8 - Fourth write carries byte
		else if (op == pfc_pkg::OP_PROGRAM && idx == 3'd3)
			step = {a, d};
		else if (idx == 3'd0 || idx == 3'd3)
			step = {pfc_pkg::CMD_ADDR_A, pfc_pkg::CMD_UNLK_A};
		else if (idx == 3'd1 || idx == 3'd4)
			step = {pfc_pkg::CMD_ADDR_B, pfc_pkg::CMD_UNLK_B};
		else if (idx == 3'd2)
			step = {pfc_pkg::CMD_ADDR_A, c};
		// R4 R13 R23 - Sixth write ends sequence
		else
			step = {pfc_pkg::CMD_ADDR_A, (op == pfc_pkg::OP_ERASE) ? pfc_pkg::CMD_ERASE : pfc_pkg::CMD_LOCK};
	endfunction : step

	// R4 R8 R13 R24 - Writes per operation
	function automatic logic [2:0] nwrites(input logic [2:0] op);
		unique case (op)
			pfc_pkg::OP_PROGRAM: nwrites = 3'd4;
			pfc_pkg::OP_ERASE:   nwrites = 3'd6;
			pfc_pkg::OP_LOCKOUT: nwrites = 3'd6;
			pfc_pkg::OP_ID_OUT1: nwrites = 3'd1;
			default:             nwrites = 3'd3;
		endcase
	endfunction : nwrites

	// ----------------------------------------
	// State
	// ----------------------------------------
	pfc_st_t     st_q;
	logic [2:0]  op_q;
	logic [2:0]  idx_q;
	logic [18:0] addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  rdata_q;
	logic [7:0]  prev_q;
	logic        prev_ok_q;
	logic        done_q;
	logic        refused_q;
	logic        cyc_start_q;
	logic        cyc_write_q;
	logic [18:0] cyc_addr_q;
	logic [7:0]  cyc_data_q;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;

	wire         busy      = (st_q != H_IDLE);
	wire         apb_acc   = psel && penable;
	wire         apb_wr    = apb_acc && pwrite;
	wire         ctrl_wr   = apb_wr && (paddr == pfc_pkg::REG_CTRL);
	wire  [2:0]  new_op    = pwdata[pfc_pkg::CTRL_OP_LSB +: pfc_pkg::CTRL_OP_W];
	wire         op_valid  = (new_op != 3'd0);
	// R11 - Boot block address range
	wire         in_boot   = (addr_q <= pfc_pkg::BOOT_LAST);
	wire         mapped    = (paddr == pfc_pkg::REG_CTRL) || (paddr == pfc_pkg::REG_ADDR) ||
	                         (paddr == pfc_pkg::REG_WDATA) || (paddr == pfc_pkg::REG_STATUS) ||
	                         (paddr == pfc_pkg::REG_RDATA);
	wire  [26:0] cur_step  = step(op_q, idx_q, addr_q, wdata_q);
	wire  [2:0]  last_idx  = nwrites(op_q) - 3'd1;
	// R19 - Bit 6 stable across two reads means idle
	wire         toggle_ok = prev_ok_q && (prev_q[6] == cyc_rdata[6]);
	// R16 - Bit 7 matches written data when finished
	// A refused byte may not match in bit 7, so a stopped toggle also ends the wait
	wire         poll_ok   = (op_q == pfc_pkg::OP_PROGRAM) && (cyc_rdata[7] == wdata_q[7]);
	wire  [31:0] status    = {29'h0, refused_q, done_q, busy};
	wire  [31:0] rd_mux    = (paddr == pfc_pkg::REG_ADDR)   ? {13'h0, addr_q} :
	                         (paddr == pfc_pkg::REG_WDATA)  ? {24'h0, wdata_q} :
	                         (paddr == pfc_pkg::REG_STATUS) ? status :
	                         (paddr == pfc_pkg::REG_RDATA)  ? {24'h0, rdata_q} : 32'h0000_0000;

	pfc_bus_cycle u_cycle (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.start           (cyc_start_q),
		.is_write        (cyc_write_q),
		.addr            (cyc_addr_q),
		.wdata           (cyc_data_q),
		.done            (cyc_done),
		.rdata           (cyc_rdata),
		.byte_address    (byte_address),
		.chip_sel_n      (chip_sel_n),
		.out_en_n        (out_en_n),
		.wr_en_n         (wr_en_n),
		.data_lines_o    (data_lines_o),
		.data_lines_oe_n (data_lines_oe_n),
		.data_lines_i    (data_lines_i)
	);

	// ----------------------------------------
	// APB slave: one wait state, answer in access phase
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !pready && !penable ? 1'b0 : (psel && penable && !pready);
			pslverr <= psel && penable && !pready && (!mapped || (paddr == pfc_pkg::REG_CTRL && pwrite && busy));
			prdata  <= rd_mux;
		end
	end

	wire take = apb_acc && pready;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q        <= H_IDLE;
			op_q        <= 3'd0;
			idx_q       <= 3'd0;
			addr_q      <= 19'h0_0000;
			wdata_q     <= 8'hFF;
			rdata_q     <= 8'h00;
			prev_q      <= 8'h00;
			prev_ok_q   <= 1'b0;
			done_q      <= 1'b0;
			refused_q   <= 1'b0;
			cyc_start_q <= 1'b0;
			cyc_write_q <= 1'b0;
			cyc_addr_q  <= 19'h0_0000;
			cyc_data_q  <= 8'h00;
		end else begin
			cyc_start_q <= 1'b0;
			if (take && pwrite && !busy && paddr == pfc_pkg::REG_ADDR)
				addr_q <= pwdata[18:0];
			if (take && pwrite && !busy && paddr == pfc_pkg::REG_WDATA)
				wdata_q <= pwdata[7:0];
			unique case (st_q)
				H_IDLE: if (take && ctrl_wr && op_valid) begin
					op_q      <= new_op;
					idx_q     <= 3'd0;
					done_q    <= 1'b0;
					prev_ok_q <= 1'b0;
					refused_q <= 1'b0;
					st_q      <= (new_op == pfc_pkg::OP_READ) ? H_READ : H_CMD;
					cyc_start_q <= 1'b1;
					cyc_write_q <= (new_op != pfc_pkg::OP_READ);
					cyc_addr_q  <= (new_op == pfc_pkg::OP_READ) ? addr_q : pfc_pkg::CMD_ADDR_A;
					cyc_data_q  <= (new_op == pfc_pkg::OP_ID_OUT1) ? pfc_pkg::CMD_ID_OUT : pfc_pkg::CMD_UNLK_A;
				end
				H_CMD: if (cyc_done) begin
					// R22 - Issue next unlock or command step
					if (idx_q == last_idx) begin
						st_q <= (op_q == pfc_pkg::OP_PROGRAM || op_q == pfc_pkg::OP_ERASE) ? H_POLL : H_END;
						cyc_start_q <= (op_q == pfc_pkg::OP_PROGRAM || op_q == pfc_pkg::OP_ERASE);
						cyc_write_q <= 1'b0;
						cyc_addr_q  <= addr_q;
					end else begin
						idx_q       <= idx_q + 3'd1;
						cyc_start_q <= 1'b1;
						cyc_write_q <= 1'b1;
						{cyc_addr_q, cyc_data_q} <= step(op_q, idx_q + 3'd1, addr_q, wdata_q);
					end
				end
				H_POLL: if (cyc_done) begin
					// R18 - Poll from first read after last write
					prev_q    <= cyc_rdata;
					prev_ok_q <= 1'b1;
					if (toggle_ok || poll_ok) begin
						rdata_q <= cyc_rdata;
						// R12 R26 - Report byte that did not take
						refused_q <= (op_q == pfc_pkg::OP_PROGRAM) && (cyc_rdata != wdata_q);
						st_q    <= H_END;
					end else
						cyc_start_q <= 1'b1;
				end
				H_READ: if (cyc_done) begin
					// R1 - Captured read byte
					rdata_q <= cyc_rdata;
					st_q    <= H_END;
				end
				H_END: begin
					done_q <= 1'b1;
					st_q   <= H_IDLE;
				end
			endcase
		end
	end

	wire unused_ok = &{1'b0, cur_step, in_boot};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_write_strobes: assert property (@(posedge ref_clk) disable iff (rst) // R20
		!wr_en_n |-> (out_en_n && !chip_sel_n)) else $error("write strobe with OE low or CE high");
	chk_strobe_width: assert property (@(posedge ref_clk) disable iff (rst) // R21
		$fell(wr_en_n) |-> !wr_en_n [*4]) else $error("write pulse too short");
	chk_read_strobes: assert property (@(posedge ref_clk) disable iff (rst) // R1
		!out_en_n |-> (wr_en_n && data_lines_oe_n)) else $error("read with WE low or data driven");
	chk_data_hold: assert property (@(posedge ref_clk) disable iff (rst) // R9
		$rose(wr_en_n) |-> (!data_lines_oe_n && $stable(data_lines_o) && $stable(byte_address)))
		else $error("data not held at WE rise");
	chk_unlock_first: assert property (@(posedge ref_clk) disable iff (rst) // R22
		(st_q == H_CMD && idx_q == 3'd0 && $fell(wr_en_n) && op_q != pfc_pkg::OP_ID_OUT1)
		|-> (byte_address == pfc_pkg::CMD_ADDR_A && data_lines_o == pfc_pkg::CMD_UNLK_A))
		else $error("first unlock write wrong");
	chk_cmd_step: assert property (@(posedge ref_clk) disable iff (rst) // R22
		(st_q == H_CMD && $fell(wr_en_n) && op_q != pfc_pkg::OP_ID_OUT1)
		|-> ({byte_address, data_lines_o} == cur_step)) else $error("command step address or data wrong");
	chk_apb_wait: assert property (@(posedge ref_clk) disable iff (rst)
		(psel && !penable) ##1 (psel && penable) |-> ##1 pready) else $error("APB answer late");
endmodule : pfc_host
`default_nettype wire

// ==== pfc_pkg.sv ====
`default_nettype none
package pfc_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] REG_CTRL    = 12'h000;
	localparam logic [11:0] REG_ADDR    = 12'h004;
	localparam logic [11:0] REG_WDATA   = 12'h008;
	localparam logic [11:0] REG_STATUS  = 12'h00C;
	localparam logic [11:0] REG_RDATA   = 12'h010;
	// CTRL fields: write starts an operation
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W   = 3;
	// STATUS fields
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_REFUSED = 2;
	// Operation codes
	localparam logic [2:0] OP_READ    = 3'h1;
	localparam logic [2:0] OP_PROGRAM = 3'h2;
	localparam logic [2:0] OP_ERASE   = 3'h3;
	localparam logic [2:0] OP_LOCKOUT = 3'h4;
	localparam logic [2:0] OP_ID_IN   = 3'h5;
	localparam logic [2:0] OP_ID_OUT  = 3'h6;
	localparam logic [2:0] OP_ID_OUT1 = 3'h7;
	// ----------------------------------------
	// Device command codes
	// ----------------------------------------
	localparam logic [18:0] CMD_ADDR_A = 19'h0_5555;
	localparam logic [18:0] CMD_ADDR_B = 19'h0_2AAA;
	localparam logic [7:0]  CMD_UNLK_A = 8'hAA;
	localparam logic [7:0]  CMD_UNLK_B = 8'h55;
	localparam logic [7:0]  CMD_PROG   = 8'hA0;
	localparam logic [7:0]  CMD_SETUP  = 8'h80;
	localparam logic [7:0]  CMD_ERASE  = 8'h10;
	localparam logic [7:0]  CMD_LOCK   = 8'h40;
	localparam logic [7:0]  CMD_ID_IN  = 8'h90;
	localparam logic [7:0]  CMD_ID_OUT = 8'hF0;
	localparam logic [18:0] BOOT_LAST  = 19'h0_3FFF;
	localparam logic [18:0] LOCK_ADDR  = 19'h0_0002;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int STROBE_NS     = 40;
	localparam int STROBE_CYC    = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FILTER_NS     = 15;
	localparam int FILTER_CYC    = (FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACCESS_NS     = 60;
	localparam int ACCESS_CYC    = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_CYC       = 2;
	localparam logic [7:0] PW_CYC = 8'(STROBE_CYC > FILTER_CYC ? STROBE_CYC : FILTER_CYC + 1);
	localparam logic [7:0] RD_CYC = 8'(ACCESS_CYC);
	localparam logic [7:0] GP_CYC = 8'(GAP_CYC);
endpackage : pfc_pkg
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [7:0] MFR = 8'h3C; // arbitrary
	localparam logic [7:0] DEV = 8'hC3; // arbitrary
	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, ref_lock;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [18:0] byte_address, a;
	logic        chip_sel_n, out_en_n, wr_en_n, data_lines_oe_n, dq_drive;
	logic [7:0]  data_lines_o, data_lines_i, dq_out, d;
	logic [7:0]  ref_mem [int];
	int          bad_count, checks_done;

	assign data_lines_i = (data_lines_oe_n === 1'b0) ? data_lines_o : dq_out;

	pfc_host u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.byte_address(byte_address), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n), .data_lines_i(data_lines_i));
	pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.byte_address(byte_address),
		.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .data_lines(data_lines_i),
		.dq_out(dq_out), .dq_drive(dq_drive));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic logic [7:0] ref_rd(input logic [18:0] x);
		return ref_mem.exists(int'(x)) ? ref_mem[int'(x)] : 8'hFF;
	endfunction : ref_rd

	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle;
		do begin
			apb(1'b0, pfc_pkg::REG_STATUS, 32'h0000_0000);
		end while (rv[pfc_pkg::ST_BUSY] !== 1'b0);
	endtask : wait_idle

	task automatic op(input logic [2:0] code, input logic [18:0] ad, input logic [7:0] wd);
		apb(1'b1, pfc_pkg::REG_ADDR, {13'h0000, ad});
		apb(1'b1, pfc_pkg::REG_WDATA, {24'h00_0000, wd});
		apb(1'b1, pfc_pkg::REG_CTRL, {29'h0000_0000, code});
		wait_idle();
	endtask : op

	task automatic rd_exp(input logic [18:0] ad, input logic [7:0] exp);
		op(pfc_pkg::OP_READ, ad, 8'h00);
		apb(1'b0, pfc_pkg::REG_RDATA, 32'h0000_0000);
		chk("rdata", rv, {24'h00_0000, exp});
	endtask : rd_exp

	task automatic prog(input logic [18:0] ad, input logic [7:0] wd);
		if (!(ref_lock && ad <= 19'h0_3FFF)) ref_mem[int'(ad)] = ref_rd(ad) & wd;
		op(pfc_pkg::OP_PROGRAM, ad, wd);
		// Status bits: refused, done, busy
		chk("prog_status", {29'h0000_0000, rv[2:0]}, {29'h0000_0000, ref_rd(ad) != wd, 2'b10});
		rd_exp(ad, ref_rd(ad));
	endtask : prog

	task automatic erase_ref;
		foreach (ref_mem[k]) if (!(ref_lock && k <= 16383)) ref_mem[k] = 8'hFF;
	endtask : erase_ref

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, ref_lock} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		checks_done = 0;
		rv = $urandom(34);
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, pfc_pkg::REG_STATUS, 32'h0000_0000);
		chk("status_reset", rv, 32'h0000_0000);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk("unmapped_err", {31'h0000_0000, err}, 32'h0000_0001);
		// erase, with a refused command write while busy
		apb(1'b1, pfc_pkg::REG_CTRL, {29'h0000_0000, pfc_pkg::OP_ERASE});
		apb(1'b1, pfc_pkg::REG_CTRL, {29'h0000_0000, pfc_pkg::OP_READ});
		chk("busy_err", {31'h0000_0000, err}, 32'h0000_0001);
		wait_idle();
		erase_ref();
		// boot edges and random main bytes, then overwrite
		prog(19'h0_0000, 8'($urandom));
		prog(19'h0_3FFF, 8'($urandom));
		prog(19'h0_4000, 8'($urandom));
		for (int i = 0; i < 4; i++) begin
			a = 19'h0_4000 + 19'($urandom_range(0, 32'h0007_BFFF));
			rd_exp(a, ref_rd(a));
			prog(a, 8'($urandom));
			prog(a, 8'($urandom));
		end
		op(pfc_pkg::OP_ID_IN, 19'h0_0000, 8'h00);
		rd_exp(19'h0_0000, MFR);
		rd_exp(19'h0_0001, DEV);
		rd_exp(19'h0_0002, 8'h00);
		op(pfc_pkg::OP_ID_OUT, 19'h0_0000, 8'h00);
		rd_exp(19'h0_0002, ref_rd(19'h0_0002));
		op(pfc_pkg::OP_LOCKOUT, 19'h0_0000, 8'h00);
		ref_lock = 1'b1;
		op(pfc_pkg::OP_ID_IN, 19'h0_0000, 8'h00);
		rd_exp(19'h0_0002, 8'h01);
		op(pfc_pkg::OP_ID_OUT1, 19'h0_0000, 8'hF0);
		rd_exp(19'h0_0002, ref_rd(19'h0_0002));
		// locked boot refuses, main array still programs
		prog(19'h0_3FFF, 8'h00);
		prog(19'h0_0000, 8'h00);
		d = 8'($urandom);
		prog(19'h0_4001, d);
		// erase spares the locked boot block
		op(pfc_pkg::OP_ERASE, 19'h0_0000, 8'h00);
		erase_ref();
		rd_exp(19'h0_3FFF, ref_rd(19'h0_3FFF));
		rd_exp(19'h0_4001, 8'hFF);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
